// ### shared/charger_supervisor_cfg.svh
`ifndef CHARGER_SUPERVISOR_CFG_SVH
`define CHARGER_SUPERVISOR_CFG_SVH

// Clock rate and derived one-second tick
`define CLK_HZ 125000000
`define SEC_CYCLES (`CLK_HZ)

// Hardware watchdog times in seconds (longest figures)
`define WDG_USB_SHORT_S 336
`define WDG_OTHER_SHORT_S 855
`define WDG_USB_LONG_S 672
`define WDG_OTHER_LONG_S 1709

// PWM dimming
`define PWM_HZ 128
`define PWM_STEPS 255
`define PWM_TICK_CYCLES (`CLK_HZ / (`PWM_HZ * `PWM_STEPS))

// Reset values
`define LED_PULLDOWN_RST 1'b1
`define WDG_TIME_RST 7'h7F
`define CUR_RST 4'h0
`define VOLT_RST 6'h00
`define MIN_BATTERY_VOLTAGE_THRESHOLD_RST 8'h00

`endif

// ### shared/charger_supervisor_pkg.sv
package charger_supervisor_pkg;

  typedef enum logic [1:0] {
    CTRL_HW = 2'b00,
    CTRL_SW = 2'b01
  } ctrl_mode_t;

  typedef enum logic [1:0] {
    LED_SUP_MID = 2'b00,
    LED_SUP_WALL = 2'b01,
    LED_SUP_EXT = 2'b11
  } led_supply_t;

endpackage

// ### hw/sync2.sv
`timescale 1ns/1ps
`include "charger_supervisor_cfg.svh"

module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ### hw/pwm_dimmer.sv
`timescale 1ns/1ps
`include "charger_supervisor_cfg.svh"

module pwm_dimmer #(
  parameter int TICK = `PWM_TICK_CYCLES,
  parameter int STEPS = `PWM_STEPS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] duty,
  output logic pwm_out
);

  logic [15:0] div_reg;
  logic [7:0] phase_reg;
  logic tick;

  assign tick = (div_reg == 16'(TICK - 1));

  // ----------------------------------------
  // Tick divider and phase counter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_reg <= 16'h0000;
    end else if (tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_reg <= 8'h00;
    end else if (tick) begin
      if (phase_reg == 8'(STEPS - 1)) begin
        phase_reg <= 8'h00;
      end else begin
        phase_reg <= phase_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (phase_reg < duty);
    end
  end

endmodule

// ### hw/charger_supervisor_control.sv
`timescale 1ns/1ps
`include "charger_supervisor_cfg.svh"


module charger_supervisor_control
  import charger_supervisor_pkg::*;
#(
  parameter int SEC_CYCLES = `SEC_CYCLES,
  parameter int WDG_USB_SHORT_S = `WDG_USB_SHORT_S,
  parameter int WDG_OTHER_SHORT_S = `WDG_OTHER_SHORT_S,
  parameter int WDG_USB_LONG_S = `WDG_USB_LONG_S,
  parameter int WDG_OTHER_LONG_S = `WDG_OTHER_LONG_S,
  parameter int PWM_TICK = `PWM_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_on_reset_n,
  input wire logic cfg_temp_gate_disable,
  input wire logic cfg_source_dependency,
  input wire logic cfg_wdg_long,
  input wire logic cfg_detect_invert,
  input wire logic vbus_detect_in,
  input wire logic wall_charger_input,
  input wire logic temp_low_ok_in,
  input wire logic temp_high_ok_in,
  input wire logic battery_removed_in,
  input wire logic charger_type_detect_in,
  input wire logic boost_short_in,
  input wire logic charging_active_in,
  input wire logic state_active,
  input wire logic state_sleep,
  input wire logic charge_enable,
  input wire logic temp_int_mask,
  input wire logic watchdog_kick_bit,
  input wire logic watchdog_time_wr,
  input wire logic [6:0] watchdog_time_field,
  input wire logic charge_current_wr,
  input wire logic [3:0] charge_current_field,
  input wire logic charge_voltage_wr,
  input wire logic [5:0] charge_voltage_field,
  input wire logic limit_wr,
  input wire logic [3:0] limit_current_in,
  input wire logic [5:0] limit_voltage_in,
  input wire logic limit_lock_wr,
  input wire logic boost_mode_wr,
  input wire logic boost_mode_select,
  input wire logic led_sw_enable,
  input wire logic [1:0] led_supply_sel,
  input wire logic [1:0] led_current_sel,
  input wire logic [7:0] led_duty,
  input wire logic led_pulldown_wr,
  input wire logic led_pulldown_val,
  input wire logic min_battery_voltage_threshold_wr,
  input wire logic [7:0] min_battery_voltage_threshold_in,
  output logic charge_run,
  output logic temp_monitor_en,
  output logic temp_ok,
  output logic temp_irq,
  output logic ctrl_sw,
  output logic wdg_expired,
  output logic [3:0] charge_current_out,
  output logic [5:0] charge_voltage_out,
  output logic limit_locked,
  output logic presence_detect_en,
  output logic battery_removed_irq,
  output logic led_on,
  output logic led_pulldown,
  output logic [1:0] led_supply,
  output logic [1:0] led_current,
  output logic boost_on,
  output logic boost_short_irq,
  output logic usb_port_detected,
  output logic [7:0] min_battery_voltage_threshold
);

  logic vbus_s, wall_s, tlo_s, thi_s, brem_s, det_s, short_s;
  logic pwm;
  logic in_window;
  logic in_window_reg;
  logic temp_valid_reg;
  logic brem_reg;
  logic sec_tick;
  logic [26:0] sec_div_reg;
  logic [10:0] wdg_cnt_reg;
  logic [10:0] hw_timeout;
  logic [3:0] cur_req_reg;
  logic [5:0] volt_req_reg;
  logic [6:0] wdg_time_reg;
  logic [3:0] lim_cur_reg;
  logic [5:0] lim_volt_reg;
  logic sw_write;
  logic sw_restart;
  logic supply_present;
  ctrl_mode_t mode_reg;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  sync2 #(.W(7)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({vbus_detect_in, wall_charger_input, temp_low_ok_in, temp_high_ok_in,
        battery_removed_in, charger_type_detect_in, boost_short_in}),
    .q({vbus_s, wall_s, tlo_s, thi_s, brem_s, det_s, short_s})
  );

  pwm_dimmer #(.TICK(PWM_TICK)) u_pwm (
    .clk(clk),
    .rst_n(rst_n),
    .duty(led_duty),
    .pwm_out(pwm)
  );

  // ----------------------------------------
  // Temperature window
  // ----------------------------------------
  assign supply_present = vbus_s | wall_s;
  assign temp_monitor_en = supply_present;
  assign in_window = tlo_s & thi_s;
  assign temp_ok = temp_valid_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_window_reg <= 1'b0;
      temp_valid_reg <= 1'b0;
      temp_irq <= 1'b0;
    end else begin
      in_window_reg <= in_window;
      temp_valid_reg <= supply_present & in_window;
      temp_irq <= supply_present & (in_window != in_window_reg) & ~temp_int_mask;
    end
  end

  // ----------------------------------------
  // Control mode and watchdog
  // ----------------------------------------
  assign sw_write = watchdog_kick_bit | watchdog_time_wr | charge_current_wr | charge_voltage_wr;
  assign sw_restart = watchdog_kick_bit | watchdog_time_wr;
  assign ctrl_sw = (mode_reg == CTRL_SW);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_reg <= CTRL_HW;
    end else begin
      case (mode_reg)
        CTRL_HW: begin
          if (sw_write) begin
            mode_reg <= CTRL_SW;
          end
        end
        CTRL_SW: begin
          if (!charge_enable) begin
            mode_reg <= CTRL_HW;
          end
        end
        default: begin
          mode_reg <= CTRL_HW;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdg_time_reg <= `WDG_TIME_RST;
      cur_req_reg <= `CUR_RST;
      volt_req_reg <= `VOLT_RST;
    end else begin
      if (watchdog_time_wr) begin
        wdg_time_reg <= watchdog_time_field;
      end
      if (charge_current_wr) begin
        cur_req_reg <= charge_current_field;
      end
      if (charge_voltage_wr) begin
        volt_req_reg <= charge_voltage_field;
      end
    end
  end

  always_comb begin
    if (cfg_source_dependency && usb_port_detected) begin
      hw_timeout = cfg_wdg_long ? 11'(WDG_USB_LONG_S) : 11'(WDG_USB_SHORT_S);
    end else begin
      hw_timeout = cfg_wdg_long ? 11'(WDG_OTHER_LONG_S) : 11'(WDG_OTHER_SHORT_S);
    end
  end

  assign sec_tick = (sec_div_reg == 27'(SEC_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rst_n || sw_restart || !charge_enable) begin
      sec_div_reg <= 27'h0000000;
    end else if (sec_tick) begin
      sec_div_reg <= 27'h0000000;
    end else begin
      sec_div_reg <= sec_div_reg + 27'h0000001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdg_cnt_reg <= 11'h000;
      wdg_expired <= 1'b0;
    end else if (!charge_enable) begin
      wdg_cnt_reg <= 11'h000;
      wdg_expired <= 1'b0;
    end else if (sw_restart) begin
      wdg_cnt_reg <= 11'h000;
      wdg_expired <= (watchdog_time_wr ? watchdog_time_field : wdg_time_reg) == 7'h00;
    end else if (sec_tick && !wdg_expired) begin
      wdg_cnt_reg <= wdg_cnt_reg + 11'h001;
      if (ctrl_sw) begin
        wdg_expired <= (wdg_cnt_reg + 11'h001) >= {4'h0, wdg_time_reg};
      end else begin
        wdg_expired <= (wdg_cnt_reg + 11'h001) >= hw_timeout;
      end
    end
  end

  // ----------------------------------------
  // Limit registers, power-on reset domain
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!power_on_reset_n) begin
      lim_cur_reg <= `CUR_RST;
      lim_volt_reg <= `VOLT_RST;
      limit_locked <= 1'b0;
    end else begin
      if (limit_wr && !limit_locked) begin
        lim_cur_reg <= limit_current_in;
        lim_volt_reg <= limit_voltage_in;
      end
      if (limit_lock_wr) begin
        limit_locked <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      charge_current_out <= `CUR_RST;
      charge_voltage_out <= `VOLT_RST;
    end else begin
      charge_current_out <= (cur_req_reg > lim_cur_reg) ? lim_cur_reg : cur_req_reg;
      charge_voltage_out <= (volt_req_reg > lim_volt_reg) ? lim_volt_reg : volt_req_reg;
    end
  end

  // ----------------------------------------
  // Battery presence and charge gating
  // ----------------------------------------
  // Presence detect enable
  assign presence_detect_en = charge_enable | state_active | state_sleep;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      brem_reg <= 1'b0;
      battery_removed_irq <= 1'b0;
    end else begin
      brem_reg <= brem_s & presence_detect_en;
      battery_removed_irq <= brem_s & presence_detect_en & ~brem_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      charge_run <= 1'b0;
    end else begin
      charge_run <= charge_enable & supply_present & ~wdg_expired & ~brem_reg
                    & (cfg_temp_gate_disable | in_window) & ~boost_on;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      usb_port_detected <= 1'b0;
    end else begin
      usb_port_detected <= det_s ^ cfg_detect_invert;
    end
  end

  // ----------------------------------------
  // Indicator LED
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      led_pulldown <= `LED_PULLDOWN_RST;
      led_on <= 1'b0;
      led_supply <= LED_SUP_MID;
      led_current <= 2'h0;
    end else begin
      if (led_pulldown_wr) begin
        led_pulldown <= led_pulldown_val;
      end
      if (led_sw_enable) begin
        led_on <= pwm;
        led_supply <= (led_supply_sel == 2'h2) ? LED_SUP_EXT : led_supply_sel;
        led_current <= led_current_sel;
      end else begin
        led_on <= ~ctrl_sw & charging_active_in & charge_run;
        led_supply <= vbus_s ? LED_SUP_MID : LED_SUP_WALL;
        led_current <= 2'h0;
      end
    end
  end

  // ----------------------------------------
  // Boost mode
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boost_on <= 1'b0;
      boost_short_irq <= 1'b0;
    end else begin
      boost_short_irq <= 1'b0;
      if (boost_on && short_s) begin
        boost_on <= 1'b0;
        boost_short_irq <= 1'b1;
      end else if (boost_mode_wr) begin
        boost_on <= boost_mode_select;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      min_battery_voltage_threshold <= `MIN_BATTERY_VOLTAGE_THRESHOLD_RST;
    end else if (min_battery_voltage_threshold_wr) begin
      min_battery_voltage_threshold <= min_battery_voltage_threshold_in;
    end
  end

endmodule

// ### verification/charger_phy_model.sv
`timescale 1ns/1ps
module charger_phy_model (
  input wire logic port_present,
  input wire logic invert,
  output logic charger_type_detect_in
);
  // ----------
  // Detect line
  // ----------
  // Detect level polarity
  assign charger_type_detect_in = port_present ^ invert;
endmodule

// ### verification/charger_supervisor_checker.sv
`timescale 1ns/1ps
module charger_supervisor_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_on_reset_n,
  input wire logic cfg_temp_gate_disable,
  input wire logic vbus_detect_in,
  input wire logic wall_charger_input,
  input wire logic battery_removed_in,
  input wire logic boost_short_in,
  input wire logic charging_active_in,
  input wire logic state_active,
  input wire logic state_sleep,
  input wire logic charge_enable,
  input wire logic temp_int_mask,
  input wire logic watchdog_kick_bit,
  input wire logic watchdog_time_wr,
  input wire logic charge_current_wr,
  input wire logic charge_voltage_wr,
  input wire logic led_sw_enable,
  input wire logic charge_run,
  input wire logic temp_monitor_en,
  input wire logic temp_ok,
  input wire logic temp_irq,
  input wire logic ctrl_sw,
  input wire logic wdg_expired,
  input wire logic limit_locked,
  input wire logic presence_detect_en,
  input wire logic led_on,
  input wire logic boost_on,
  input wire logic boost_short_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------
  // Properties
  // ----------
  a_monitor_with_supply: assert property (
    (vbus_detect_in || wall_charger_input) [*4] |-> temp_monitor_en) else $error("monitor off");
  a_temp_gates_run: assert property (
    (!temp_ok && !cfg_temp_gate_disable) [*2] |-> !charge_run) else $error("run out of window");
  a_temp_irq_pulse: assert property (
    temp_irq |=> !temp_irq) else $error("temp irq too long");
  a_temp_irq_masked: assert property (
    temp_int_mask [*3] |-> !temp_irq) else $error("masked temp irq");
  a_sw_write_takes: assert property (
    (watchdog_kick_bit || watchdog_time_wr || charge_current_wr || charge_voltage_wr)
      && charge_enable ##1 charge_enable |-> ctrl_sw) else $error("no software control");
  a_expiry_stops_run: assert property (
    wdg_expired |=> !charge_run) else $error("run after expiry");
  a_lock_holds: assert property (
    limit_locked && power_on_reset_n |=> limit_locked) else $error("lock dropped");
  a_removal_stops_run: assert property (
    battery_removed_in [*6] |-> !charge_run) else $error("run without battery");
  a_presence_enabled: assert property (
    (charge_enable || state_active || state_sleep) |-> presence_detect_en)
    else $error("presence detect off");
  a_short_stops_boost: assert property (
    boost_short_in [*5] |-> !boost_on) else $error("boost on during short");
  a_hw_led_idle: assert property (
    (!led_sw_enable && !charging_active_in) [*3] |-> !led_on) else $error("led on idle");
  c_temp_irq: cover property (temp_irq);
  c_sw_expiry: cover property (wdg_expired && ctrl_sw);
  c_boost_short: cover property (boost_short_irq);
endmodule
bind charger_supervisor_control charger_supervisor_checker chk_i (.*);

// ### verification/charger_supervisor_control_bench.sv
`timescale 1ns/1ps
`include "charger_supervisor_cfg.svh"
module charger_supervisor_control_bench;
  logic clk, rst_n, power_on_reset_n, cfg_temp_gate_disable, cfg_source_dependency;
  logic cfg_wdg_long, cfg_detect_invert, vbus_detect_in, wall_charger_input, temp_low_ok_in;
  logic temp_high_ok_in, battery_removed_in, charger_type_detect_in, boost_short_in;
  logic charging_active_in, state_active, state_sleep, charge_enable, temp_int_mask;
  logic watchdog_kick_bit, watchdog_time_wr, charge_current_wr, charge_voltage_wr, limit_wr;
  logic limit_lock_wr, boost_mode_wr, boost_mode_select, led_sw_enable, led_pulldown_wr;
  logic led_pulldown_val, min_battery_voltage_threshold_wr, port_present;
  logic [6:0] watchdog_time_field;
  logic [3:0] charge_current_field, limit_current_in, charge_current_out;
  logic [5:0] charge_voltage_field, limit_voltage_in, charge_voltage_out;
  logic [1:0] led_supply_sel, led_current_sel, led_supply, led_current;
  logic [7:0] led_duty, min_battery_voltage_threshold_in, min_battery_voltage_threshold;
  logic charge_run, temp_monitor_en, temp_ok, temp_irq, ctrl_sw, wdg_expired, limit_locked;
  logic presence_detect_en, battery_removed_irq, led_on, led_pulldown, boost_on;
  logic boost_short_irq, usb_port_detected;
  logic [2:0] mode [6] = '{3'h5, 3'h4, 3'h7, 3'h6, 3'h1, 3'h3};
  int secs [6] = '{`WDG_USB_SHORT_S, 6, 9, 12, 6, 12};
  int fails, compares, tirq, rirq, sirq, n;
  charger_supervisor_control #(.SEC_CYCLES(10), .WDG_OTHER_SHORT_S(6),
    .WDG_USB_LONG_S(9), .WDG_OTHER_LONG_S(12), .PWM_TICK(2)) dut (.*);
  charger_phy_model phy (.port_present(port_present), .invert(cfg_detect_invert),
    .charger_type_detect_in(charger_type_detect_in));
  // -------
  // Helpers
  // -------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    tirq += temp_irq;
    rirq += battery_removed_irq;
    sirq += boost_short_irq;
  end
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task in_range(input int v, input int lo, input int hi);
    chk(32'(v >= lo && v <= hi), 32'h1);
  endtask
  task complete_run;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task wait_exp(output int k);
    k = 0;
    while (wdg_expired !== 1'b1) begin
      cyc(1);
      k++;
      if (k > 4000) begin
        fails++;
        complete_run();
      end
    end
  endtask
  task pulse_wr(input logic [2:0] sel);
    {watchdog_kick_bit, charge_current_wr, charge_voltage_wr} = sel;
    cyc(1);
    {watchdog_kick_bit, charge_current_wr, charge_voltage_wr} = 3'h0;
  endtask
  task pwm_count(input logic [7:0] d, output int k);
    led_duty = d;
    cyc(520);
    k = 0;
    repeat (510) begin
      cyc(1);
      k += led_on;
    end
  endtask
  // ---------
  // Scenarios
  // ---------
  task t_detect;
    for (int i = 0; i < 4; i++) begin
      cfg_detect_invert = i[1];
      port_present = i[0];
      cyc(5);
      chk(usb_port_detected, i[0]);
    end
    {port_present, cfg_detect_invert} = 2'h0;
  endtask
  task t_temp;
    {vbus_detect_in, charge_enable, charging_active_in} = 3'h7;
    cyc(5);
    chk(temp_monitor_en, 1);
    chk(charge_run, 1);
    n = tirq;
    temp_high_ok_in = 1'b0;
    cyc(6);
    chk(tirq - n, 1);
    chk({temp_ok, charge_run}, 0);
    n = tirq;
    temp_high_ok_in = 1'b1;
    cyc(6);
    chk(tirq - n, 1);
    chk(charge_run, 1);
    cfg_temp_gate_disable = 1'b1;
    temp_low_ok_in = 1'b0;
    cyc(6);
    chk(charge_run, 1);
    n = tirq;
    temp_int_mask = 1'b1;
    temp_low_ok_in = 1'b1;
    cyc(6);
    chk(tirq - n, 0);
    {temp_int_mask, cfg_temp_gate_disable, charge_enable, vbus_detect_in} = 4'h0;
    wall_charger_input = 1'b1;
    cyc(5);
    chk(temp_monitor_en, 1);
    wall_charger_input = 1'b0;
    cyc(5);
    chk(temp_monitor_en, 0);
  endtask
  task t_limits;
    // Host sets limits then locks them
    {limit_current_in, limit_voltage_in, limit_wr} = {4'h5, 6'h10, 1'b1};
    cyc(1);
    {limit_wr, limit_lock_wr} = 2'h1;
    cyc(1);
    {limit_current_in, limit_voltage_in, limit_wr, limit_lock_wr} = {4'hF, 6'h3F, 2'h2};
    cyc(1);
    limit_wr = 1'b0;
    {charge_current_field, charge_voltage_field} = {4'hC, 6'h30};
    pulse_wr(3'h3);
    cyc(1);
    chk(limit_locked, 1);
    chk({charge_current_out, charge_voltage_out}, {4'h5, 6'h10});
    {charge_current_field, charge_voltage_field} = {4'h3, 6'h0C};
    pulse_wr(3'h3);
    cyc(1);
    chk({charge_current_out, charge_voltage_out}, {4'h3, 6'h0C});
    rst_n = 1'b0;
    cyc(1);
    rst_n = 1'b1;
    cyc(3);
    chk(limit_locked, 1);
    power_on_reset_n = 1'b0;
    cyc(1);
    power_on_reset_n = 1'b1;
    cyc(1);
    chk(limit_locked, 0);
  endtask
  task t_sw_wdg;
    {vbus_detect_in, charge_enable} = 2'h3;
    cyc(3);
    {watchdog_time_field, watchdog_time_wr} = {7'h05, 1'b1};
    cyc(1);
    watchdog_time_wr = 1'b0;
    chk(ctrl_sw, 1);
    cyc(20);
    pulse_wr(3'h4);
    wait_exp(n);
    in_range(n, 38, 53);
    cyc(1);
    chk(charge_run, 0);
    charge_enable = 1'b0;
    cyc(1);
    {charge_enable, watchdog_time_field, watchdog_time_wr} = {1'b1, 7'h00, 1'b1};
    cyc(1);
    watchdog_time_wr = 1'b0;
    cyc(2);
    chk(wdg_expired, 1);
    for (int i = 0; i < 3; i++) begin
      charge_enable = 1'b0;
      cyc(2);
      chk(ctrl_sw, 0);
      charge_enable = 1'b1;
      pulse_wr(3'h1 << i);
      chk(ctrl_sw, 1);
    end
  endtask
  task t_hw_wdg;
    for (int i = 0; i < 6; i++) begin
      charge_enable = 1'b0;
      {cfg_source_dependency, cfg_wdg_long, port_present} = mode[i];
      cyc(6);
      charge_enable = 1'b1;
      wait_exp(n);
      in_range(n, secs[i] * 10 - 12, secs[i] * 10 + 4);
    end
    {charge_enable, port_present} = 2'h0;
  endtask
  task t_removal;
    cyc(1);
    charge_enable = 1'b1;
    cyc(3);
    chk(charge_run, 1);
    n = rirq;
    battery_removed_in = 1'b1;
    cyc(6);
    chk(rirq - n, 1);
    chk(charge_run, 0);
    {battery_removed_in, charge_enable} = 2'h0;
    for (int i = 0; i < 3; i++) begin
      {charge_enable, state_active, state_sleep} = 3'h1 << i;
      cyc(1);
      chk(presence_detect_en, 1);
    end
    charge_enable = 1'b0;
    cyc(1);
    chk(presence_detect_en, 0);
  endtask
  task t_led;
    cyc(3);
    chk(led_on, 0);
    {charging_active_in, charge_enable} = 2'h3;
    cyc(3);
    chk(led_on, 1);
    {charging_active_in, charge_enable} = 2'h0;
    for (int i = 0; i < 2; i++) begin
      {led_pulldown_val, led_pulldown_wr} = {i[0], 1'b1};
      cyc(1);
      led_pulldown_wr = 1'b0;
      cyc(1);
      chk(led_pulldown, i[0]);
    end
    led_sw_enable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {led_supply_sel, led_current_sel} = {i[1:0], ~i[1:0]};
      cyc(2);
      chk({led_supply, led_current}, {i[1] ? 2'h3 : i[1:0], ~i[1:0]});
    end
    pwm_count(8'h40, n);
    in_range(n, 124, 132);
    pwm_count(8'hFF, n);
    in_range(n, 505, 510);
    led_sw_enable = 1'b0;
  endtask
  task t_boost;
    {boost_mode_select, boost_mode_wr} = 2'h3;
    cyc(1);
    boost_mode_wr = 1'b0;
    cyc(1);
    chk(boost_on, 1);
    n = sirq;
    boost_short_in = 1'b1;
    cyc(6);
    chk(boost_on, 0);
    chk(sirq - n, 1);
    {boost_short_in, boost_mode_select, boost_mode_wr} = 3'h1;
    cyc(1);
    boost_mode_wr = 1'b0;
    for (int i = 0; i < 2; i++) begin
      {min_battery_voltage_threshold_in, min_battery_voltage_threshold_wr} = {i[0] ? 8'h3C : 8'hA5, 1'b1};
      cyc(1);
      min_battery_voltage_threshold_wr = 1'b0;
      cyc(1);
      chk(min_battery_voltage_threshold, min_battery_voltage_threshold_in);
    end
  endtask
  // ----
  // Main
  // ----
  initial begin
    {rst_n, power_on_reset_n, cfg_temp_gate_disable, cfg_wdg_long, cfg_detect_invert} = '0;
    {vbus_detect_in, wall_charger_input, battery_removed_in, boost_short_in} = '0;
    {charging_active_in, state_active, state_sleep, charge_enable, temp_int_mask} = '0;
    {watchdog_kick_bit, watchdog_time_wr, charge_current_wr, charge_voltage_wr} = '0;
    {limit_wr, limit_lock_wr, boost_mode_wr, boost_mode_select, led_sw_enable} = '0;
    {led_pulldown_wr, led_pulldown_val, min_battery_voltage_threshold_wr, port_present} = '0;
    {cfg_source_dependency, temp_low_ok_in, temp_high_ok_in} = 3'h7;
    {watchdog_time_field, charge_current_field, charge_voltage_field} = '0;
    {limit_current_in, limit_voltage_in, led_supply_sel, led_current_sel} = '0;
    {led_duty, min_battery_voltage_threshold_in} = '0;
    cyc(5);
    {rst_n, power_on_reset_n} = 2'h3;
    cyc(3);
    chk({led_pulldown, limit_locked, boost_on}, 3'h4);
    t_detect();
    t_temp();
    t_limits();
    t_sw_wdg();
    t_hw_wdg();
    t_removal();
    t_led();
    t_boost();
    complete_run();
  end
endmodule
